/* hw/hcmp_defines.svh */
`ifndef HCMP_DEFINES_SVH
`define HCMP_DEFINES_SVH

// ****************************************
// APB register offsets (byte addresses)
// ****************************************
`define HCMP_A_CTRL 8'h00
`define HCMP_A_MADDR 8'h04
`define HCMP_A_WDATA 8'h08
`define HCMP_A_RDATA 8'h0C
`define HCMP_A_STATUS 8'h10
`define HCMP_A_HIRQ 8'h14
`define HCMP_A_OUTBOX 8'h18
`define HCMP_A_MBOX 8'h20
`define HCMP_A_MBOX_MASK 8'hF0

// ****************************************
// Field positions
// ****************************************
`define HCMP_CTRL_START 0
`define HCMP_CTRL_WRITE 1
`define HCMP_CTRL_BANK 2
`define HCMP_ST_BUSY 0
`define HCMP_ST_DONE 1
`define HCMP_ST_IRQ 2
`define HCMP_ST_ENDIAN 3
`define HCMP_ST_LINKCTL 4
`define HCMP_ST_ARBM 5

// ****************************************
// Host port register addresses
// ****************************************
`define HCMP_H_MBOX_LAST 8'h03
`define HCMP_H_OUTBOX 8'h04
`define HCMP_H_IRQCLR 8'h05
`define HCMP_H_GPIO 8'h70

// ****************************************
// Timing
// ****************************************
`define HCMP_CLK_NS 100
`define HCMP_MEM_STROBE_NS 200
`define HCMP_MEM_STROBE_CYC ((`HCMP_MEM_STROBE_NS + `HCMP_CLK_NS - 1) / `HCMP_CLK_NS)
`define HCMP_ARB_SETTLE_CYC 4
`define HCMP_CNT_W 4

`endif

/* hw/hcmp_pkg.sv */
package hcmp_pkg;

    typedef enum logic [2:0] {
        MEM_IDLE = 3'h0,
        MEM_WAIT = 3'h1,
        MEM_CHECK = 3'h2,
        MEM_SETUP = 3'h3,
        MEM_STROBE = 3'h4,
        MEM_RELEASE = 3'h5
    } hcmp_mem_st_e;

    typedef enum logic [0:0] {
        HST_IDLE = 1'h0,
        HST_ACK = 1'h1
    } hcmp_host_st_e;

endpackage : hcmp_pkg

/* hw/hcmp_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface hcmp_mem_if;
    logic start;
    logic write;
    logic bank;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic busy;
    logic done;
    logic [31:0] rdata;

    modport ctl (output start, output write, output bank, output addr, output wdata,
                 input busy, input done, input rdata);
    modport eng (input start, input write, input bank, input addr, input wdata,
                 output busy, output done, output rdata);
endinterface : hcmp_mem_if

`default_nettype wire

/* hw/hcmp_mem_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcmp_defines.svh"

module hcmp_mem_engine
    import hcmp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic arb_master,
    hcmp_mem_if.eng req,
    output logic [1:0] mem_bank_select_n,
    output logic mem_read_n,
    output logic mem_write_n,
    output logic [15:0] mem_addr_out,
    output logic mem_ctl_oe_n,
    output logic [31:0] mem_data_out,
    input wire logic [31:0] mem_data_in,
    output logic mem_data_oe_n,
    input wire logic peer_occupied_in,
    output logic self_occupied_out,
    output logic self_occupied_oe_n
);

    hcmp_mem_st_e state_reg, state_next;
    logic [2:0] peer_sync_reg;
    logic peer_reg;
    logic [`HCMP_CNT_W-1:0] cnt_reg, cnt_next;
    logic wr_reg, bank_reg;
    logic [31:0] rdata_reg;

    // ****************************************
    // Peer occupied input: three stages, agree filter
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peer_sync_reg <= 3'h0;
            peer_reg <= 1'h0;
        end else begin
            peer_sync_reg <= {peer_sync_reg[1:0], peer_occupied_in};
            if (peer_sync_reg[1] == peer_sync_reg[2]) begin
                peer_reg <= peer_sync_reg[2];
            end
        end
    end

    wire owns_bus = (state_reg == MEM_SETUP) || (state_reg == MEM_STROBE) || (state_reg == MEM_RELEASE);
    wire strobe_last = (cnt_reg == `HCMP_CNT_W'(`HCMP_MEM_STROBE_CYC - 1));
    wire settle_last = (cnt_reg == `HCMP_CNT_W'(`HCMP_ARB_SETTLE_CYC - 1));

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            MEM_IDLE: begin
                cnt_next = '0;
                if (req.start) begin
                    state_next = peer_reg ? MEM_WAIT : MEM_CHECK;
                end
            end
            MEM_WAIT: begin
                cnt_next = '0;
                if (!peer_reg) begin
                    state_next = MEM_CHECK;
                end
            end
            MEM_CHECK: begin
                cnt_next = cnt_reg + `HCMP_CNT_W'(1);
                if (settle_last) begin
                    cnt_next = '0;
                    state_next = (peer_reg && !arb_master) ? MEM_WAIT : MEM_SETUP;
                end
            end
            MEM_SETUP: state_next = MEM_STROBE;
            MEM_STROBE: begin
                cnt_next = cnt_reg + `HCMP_CNT_W'(1);
                if (strobe_last) begin
                    state_next = MEM_RELEASE;
                end
            end
            MEM_RELEASE: state_next = MEM_IDLE;
            default: state_next = MEM_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= MEM_IDLE;
            cnt_reg <= '0;
            wr_reg <= 1'h0;
            bank_reg <= 1'h0;
            mem_addr_out <= 16'h0000;
            mem_data_out <= 32'h00000000;
            rdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (state_reg == MEM_IDLE && req.start) begin
                wr_reg <= req.write;
                bank_reg <= req.bank;
                mem_addr_out <= req.addr;
                mem_data_out <= req.wdata;
            end
            if (state_reg == MEM_STROBE && strobe_last && !wr_reg) begin
                rdata_reg <= mem_data_in;
            end
        end
    end

    assign self_occupied_out = (state_reg == MEM_CHECK) || owns_bus;
    assign self_occupied_oe_n = !self_occupied_out;
    assign mem_ctl_oe_n = !owns_bus;
    assign mem_data_oe_n = !(owns_bus && wr_reg);
    assign mem_bank_select_n = owns_bus && (state_reg != MEM_RELEASE) ? ~(2'h1 << bank_reg) : 2'h3;
    assign mem_read_n = !(state_reg == MEM_STROBE && !wr_reg);
    assign mem_write_n = !(state_reg == MEM_STROBE && wr_reg);
    assign req.busy = (state_reg != MEM_IDLE);
    assign req.done = (state_reg == MEM_RELEASE);
    assign req.rdata = rdata_reg;

endmodule : hcmp_mem_engine

`default_nettype wire

/* hw/hcmp_top.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hcmp_defines.svh"

module hcmp_top
    import hcmp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_sel_n,
    input wire logic host_read_n,
    input wire logic host_write_n,
    input wire logic [7:0] host_reg_addr,
    input wire logic [31:0] host_data_in,
    output logic [31:0] host_data_out,
    output logic host_data_oe_n,
    output logic host_ack,
    output logic host_ack_oe_n,
    output logic host_irq_n,
    output logic host_irq_oe_n,
    input wire logic [3:0] device_addr_in,
    input wire logic [3:0] device_id_strap,
    input wire logic host_endian_strap,
    input wire logic link_control_strap,
    input wire logic arb_master_strap,
    output logic [31:0] gpio_out,
    output logic [1:0] mem_bank_select_n,
    output logic mem_read_n,
    output logic mem_write_n,
    output logic [15:0] mem_addr_out,
    output logic mem_ctl_oe_n,
    output logic [31:0] mem_data_out,
    input wire logic [31:0] mem_data_in,
    output logic mem_data_oe_n,
    input wire logic peer_occupied_in,
    output logic self_occupied_out,
    output logic self_occupied_oe_n
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] byte_swap(input logic [31:0] w);
        byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : byte_swap

    function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] set,
                                            input logic [31:0] clr);
        // Set wins over a clear landing in the same cycle
        set_clr = (cur & ~clr) | set;
    endfunction : set_clr

    // ****************************************
    // Strap capture after reset release
    // ****************************************
    logic strap_taken_reg;
    logic endian_reg;
    logic link_ctl_reg;
    logic arb_master_reg;
    logic [3:0] dev_id_reg;

    // Straps are stable around reset; a clocked capture keeps reset a pure constant load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_taken_reg <= 1'h0;
            endian_reg <= 1'h0;
            link_ctl_reg <= 1'h0;
            arb_master_reg <= 1'h0;
            dev_id_reg <= 4'h0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'h1;
            endian_reg <= host_endian_strap;
            link_ctl_reg <= link_control_strap;
            arb_master_reg <= arb_master_strap;
            dev_id_reg <= device_id_strap;
        end
    end

    // ****************************************
    // Host pin synchronisers
    // ****************************************
    localparam int HSYNC_W = 7;
    logic [HSYNC_W-1:0] hs1_reg, hs2_reg, hs3_reg, hfilt_reg;
    wire [HSYNC_W-1:0] hpins = {host_sel_n, host_read_n, host_write_n, device_addr_in};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs1_reg <= 7'h70;
            hs2_reg <= 7'h70;
            hs3_reg <= 7'h70;
            hfilt_reg <= 7'h70;
        end else begin
            hs1_reg <= hpins;
            hs2_reg <= hs1_reg;
            hs3_reg <= hs2_reg;
            // A bit changes only once stages two and three agree
            hfilt_reg <= (hs2_reg & hs3_reg) | (hfilt_reg & (hs2_reg ^ hs3_reg));
        end
    end

    wire sel_f = !hfilt_reg[6];
    wire rd_f = !hfilt_reg[5];
    wire wr_f = !hfilt_reg[4];
    wire id_match = (hfilt_reg[3:0] == dev_id_reg);
    wire host_selected = sel_f && id_match && strap_taken_reg;
    wire host_access = host_selected && (rd_f ^ wr_f);

    // ****************************************
    // Shared state
    // ****************************************
    logic [31:0] mbox_reg [0:3];
    logic [31:0] outbox_reg;
    logic irq_reg;
    logic done_reg;
    logic [31:0] gpio_reg;
    logic [2:0] ctrl_reg;
    logic [15:0] maddr_reg;
    logic [31:0] wdata_reg;

    hcmp_mem_if mif ();

    // ****************************************
    // Host port access sequence
    // ****************************************
    hcmp_host_st_e hst_reg, hst_next;
    logic host_is_read_reg;

    wire [31:0] host_win = endian_reg ? byte_swap(host_data_in) : host_data_in;
    wire host_hit_mbox = (host_reg_addr <= `HCMP_H_MBOX_LAST);
    wire host_hit_outbox = (host_reg_addr == `HCMP_H_OUTBOX);
    wire host_hit_irqclr = (host_reg_addr == `HCMP_H_IRQCLR);
    wire host_hit_gpio = (host_reg_addr == `HCMP_H_GPIO) && link_ctl_reg;

    wire [31:0] host_rword = host_hit_mbox ? mbox_reg[host_reg_addr[1:0]] :
                             host_hit_outbox ? outbox_reg :
                             host_hit_gpio ? gpio_reg : 32'h00000000;
    wire host_take = (hst_reg == HST_IDLE) && host_access;
    wire host_wr_take = host_take && wr_f;

    always_comb begin
        hst_next = hst_reg;
        case (hst_reg)
            HST_IDLE: begin
                if (host_access) begin
                    hst_next = HST_ACK;
                end
            end
            HST_ACK: begin
                if (!sel_f || (!rd_f && !wr_f)) begin
                    hst_next = HST_IDLE;
                end
            end
            default: hst_next = HST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hst_reg <= HST_IDLE;
            host_is_read_reg <= 1'h0;
            host_data_out <= 32'h00000000;
        end else begin
            hst_reg <= hst_next;
            if (host_take) begin
                host_is_read_reg <= rd_f;
                host_data_out <= endian_reg ? byte_swap(host_rword) : host_rword;
            end
        end
    end

    // wait state then ack
    // Ack falls with the select so it never stands high while the pin is released
    assign host_ack = (hst_reg == HST_ACK) && host_selected;
    assign host_ack_oe_n = !host_selected;
    assign host_data_oe_n = !((hst_reg == HST_ACK) && host_is_read_reg && host_selected);
    assign host_irq_n = !irq_reg;
    assign host_irq_oe_n = !irq_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                mbox_reg[i] <= 32'h00000000;
            end
            gpio_reg <= 32'h00000000;
        end else if (host_wr_take) begin
            if (host_hit_mbox) begin
                mbox_reg[host_reg_addr[1:0]] <= host_win;
            end
            if (host_hit_gpio) begin
                gpio_reg <= host_win;
            end
        end
    end

    assign gpio_out = gpio_reg;

    // ****************************************
    // APB slave
    // ****************************************
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = (paddr == `HCMP_A_CTRL);
    wire hit_maddr = (paddr == `HCMP_A_MADDR);
    wire hit_wdata = (paddr == `HCMP_A_WDATA);
    wire hit_rdata = (paddr == `HCMP_A_RDATA);
    wire hit_status = (paddr == `HCMP_A_STATUS);
    wire hit_hirq = (paddr == `HCMP_A_HIRQ);
    wire hit_outbox = (paddr == `HCMP_A_OUTBOX);
    wire hit_mbox = ((paddr & `HCMP_A_MBOX_MASK) == `HCMP_A_MBOX) && (paddr[1:0] == 2'h0);
    wire hit_any = hit_ctrl | hit_maddr | hit_wdata | hit_rdata | hit_status | hit_hirq | hit_outbox | hit_mbox;

    wire [31:0] status_word = {26'h0000000, arb_master_reg, link_ctl_reg, endian_reg, irq_reg,
                               done_reg, mif.busy};
    wire [31:0] apb_rword = hit_ctrl ? {29'h00000000, ctrl_reg} :
                            hit_maddr ? {16'h0000, maddr_reg} :
                            hit_wdata ? wdata_reg :
                            hit_rdata ? mif.rdata :
                            hit_status ? status_word :
                            hit_hirq ? {31'h00000000, irq_reg} :
                            hit_outbox ? outbox_reg :
                            hit_mbox ? mbox_reg[paddr[3:2]] : 32'h00000000;

    // Zero wait states: data is fetched in the setup cycle so it comes from a flop
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit_any;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (apb_setup) begin
            prdata <= apb_rword;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    // Start is refused while an access is in flight
    wire start_req = apb_wr && hit_ctrl && pwdata[`HCMP_CTRL_START] && !mif.busy;
    wire done_clr = apb_wr && hit_status && pwdata[`HCMP_ST_DONE];
    wire irq_set = apb_wr && hit_hirq && pwdata[0];
    wire irq_clr = host_wr_take && host_hit_irqclr;

    // Set-wins update of the two sticky flags
    wire [31:0] irq_word_next = set_clr({31'h00000000, irq_reg}, {31'h00000000, irq_set},
                                        {31'h00000000, irq_clr});
    wire [31:0] done_word_next = set_clr({31'h00000000, done_reg}, {31'h00000000, mif.done},
                                         {31'h00000000, done_clr});

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= 3'h0;
            maddr_reg <= 16'h0000;
            wdata_reg <= 32'h00000000;
            outbox_reg <= 32'h00000000;
        end else begin
            if (apb_wr && hit_ctrl) begin
                ctrl_reg <= {pwdata[`HCMP_CTRL_BANK], pwdata[`HCMP_CTRL_WRITE], 1'h0};
            end
            if (apb_wr && hit_maddr) begin
                maddr_reg <= pwdata[15:0];
            end
            if (apb_wr && hit_wdata) begin
                wdata_reg <= pwdata;
            end
            if (apb_wr && hit_outbox) begin
                outbox_reg <= pwdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'h0;
            done_reg <= 1'h0;
        end else begin
            irq_reg <= irq_word_next[0];
            done_reg <= done_word_next[0];
        end
    end

    // ****************************************
    // Communication memory engine
    // ****************************************
    assign mif.start = start_req;
    assign mif.write = pwdata[`HCMP_CTRL_WRITE];
    assign mif.bank = pwdata[`HCMP_CTRL_BANK];
    assign mif.addr = maddr_reg;
    assign mif.wdata = wdata_reg;

    hcmp_mem_engine u_mem (
        .clk(clk),
        .rst(rst),
        .arb_master(arb_master_reg),
        .req(mif.eng),
        .mem_bank_select_n(mem_bank_select_n),
        .mem_read_n(mem_read_n),
        .mem_write_n(mem_write_n),
        .mem_addr_out(mem_addr_out),
        .mem_ctl_oe_n(mem_ctl_oe_n),
        .mem_data_out(mem_data_out),
        .mem_data_in(mem_data_in),
        .mem_data_oe_n(mem_data_oe_n),
        .peer_occupied_in(peer_occupied_in),
        .self_occupied_out(self_occupied_out),
        .self_occupied_oe_n(self_occupied_oe_n)
    );

endmodule : hcmp_top

`default_nettype wire

/* dv/hcmp_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module hcmp_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_ack,
    input wire logic host_ack_oe_n,
    input wire logic host_irq_n,
    input wire logic host_irq_oe_n,
    input wire logic [1:0] mem_bank_select_n,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic [15:0] mem_addr_out,
    input wire logic mem_ctl_oe_n,
    input wire logic mem_data_oe_n,
    input wire logic self_occupied_out,
    input wire logic self_occupied_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ack_driven_a: assert property (host_ack |-> !host_ack_oe_n) else $error("ack not driven");
    irq_release_a: assert property (host_irq_oe_n == host_irq_n) else $error("irq pin drive");
    rd_strobe_len_a: assert property ($fell(mem_read_n) |=> !mem_read_n ##1 mem_read_n)
        else $error("read strobe length");
    wr_strobe_len_a: assert property ($fell(mem_write_n) |=> !mem_write_n ##1 mem_write_n)
        else $error("write strobe length");
    bank_onehot_a: assert property (!(mem_read_n && mem_write_n) |-> $onehot(~mem_bank_select_n))
        else $error("bank select");
    addr_hold_a: assert property (!(mem_read_n && mem_write_n) |-> $stable(mem_addr_out) && !mem_ctl_oe_n)
        else $error("address moved");
    data_dir_a: assert property (!(mem_read_n && mem_write_n) |-> mem_data_oe_n == mem_write_n)
        else $error("data direction");
    own_occupied_a: assert property (!mem_ctl_oe_n |-> self_occupied_out && !self_occupied_oe_n)
        else $error("owned without occupied");
    cover property ($fell(mem_read_n));
    cover property ($fell(mem_write_n));
    cover property ($rose(host_ack));
endmodule : hcmp_properties

bind hcmp_top hcmp_properties hcmp_properties_i (.*);

`default_nettype wire

/* dv/hcmp_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module hcmp_mem_model (
    input wire logic clk,
    input wire logic [1:0] mem_bank_select_n,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic [15:0] mem_addr_out,
    input wire logic [31:0] mem_data_out,
    output logic [31:0] mem_data_in
);
    logic [31:0] cells [logic [16:0]];
    wire logic [16:0] key = {~mem_bank_select_n[1], mem_addr_out};
    wire logic hit = !(&mem_bank_select_n);
    initial mem_data_in = 32'h5A5A5A5A;
    always @(posedge clk) begin
        if (!mem_write_n && hit)
            cells[key] = mem_data_out;
        if (!mem_read_n && hit && cells.exists(key))
            mem_data_in <= cells[key];
        else
            mem_data_in <= ~mem_data_in;
    end
endmodule : hcmp_mem_model

`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcmp_defines.svh"

module tb_top;
    logic clk, rst, psel, penable, pwrite, host_sel_n, host_read_n, host_write_n, peer_occupied_in, perr, ok;
    logic [31:0] pwdata, prdata, host_data_in, host_data_out, gpio_out, mem_data_out, mem_data_in, q;
    logic [7:0] paddr, host_reg_addr;
    logic [3:0] device_addr_in, device_id_strap;
    logic host_endian_strap, link_control_strap, arb_master_strap;
    logic [15:0] mem_addr_out;
    logic [1:0] mem_bank_select_n;
    logic pready, pslverr, host_data_oe_n, host_ack, host_ack_oe_n, host_irq_n, host_irq_oe_n;
    logic mem_read_n, mem_write_n, mem_ctl_oe_n, mem_data_oe_n, self_occupied_out, self_occupied_oe_n;
    int miscompares = 0;
    int num_checks = 0;

    hcmp_top hcmp_top_i (.*);
    hcmp_mem_model hcmp_mem_model_i (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            miscompares++;
            final_report();
        end
    endtask : apb

    task automatic mstart(input logic w, input logic b, input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, `HCMP_A_MADDR, {16'h0000, a});
        apb(1'b1, `HCMP_A_WDATA, d);
        apb(1'b1, `HCMP_A_CTRL, {29'h0, b, w, 1'b1});
    endtask : mstart

    task automatic mwait;
        int n;
        for (n = 0; n < 40; n++) begin
            apb(1'b0, `HCMP_A_STATUS, 32'h0);
            if (q[0] === 1'b0) break;
        end
        if (n == 40) begin
            miscompares++;
            final_report();
        end
        apb(1'b0, `HCMP_A_RDATA, 32'h0);
    endtask : mwait

    // strobes held until acknowledge, then idle before the next access
    task automatic hacc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        host_reg_addr <= a;
        host_data_in <= d;
        host_sel_n <= 1'b0;
        host_read_n <= w;
        host_write_n <= !w;
        ok = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(negedge clk);
            ok = (host_ack === 1'b1);
        end
        q = host_data_out;
        check({31'h0, ok}, {31'h0, device_addr_in == device_id_strap});
        check({31'h0, host_data_oe_n}, {31'h0, w || !ok});
        @(posedge clk);
        host_sel_n <= 1'b1;
        host_read_n <= 1'b1;
        host_write_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : hacc

    task automatic t_mem;
        for (int b = 0; b < 2; b++) begin
            mstart(1'b1, b[0], 16'h00A5, b ? 32'hC0DE0001 : 32'hC0DE0000);
            mwait();
        end
        for (int b = 0; b < 2; b++) begin
            mstart(1'b0, b[0], 16'h00A5, 32'h0);
            mwait();
            check(q, b ? 32'hC0DE0001 : 32'hC0DE0000);
        end
    endtask : t_mem

    task automatic t_peer;
        for (int k = 0; k < 2; k++) begin
            if (k == 0) peer_occupied_in <= 1'b1;
            apb(1'b1, `HCMP_A_MADDR, 32'h000000A5);
            apb(1'b1, `HCMP_A_WDATA, 32'h0);
            // Second pass raises occupied inside the claim window: the slave must yield
            peer_occupied_in <= 1'b1;
            apb(1'b1, `HCMP_A_CTRL, 32'h00000005);
            ok = 1'b1;
            repeat (30) begin
                @(negedge clk);
                if (!mem_read_n || !mem_ctl_oe_n) ok = 1'b0;
            end
            check({31'h0, ok}, 32'h1);
            check({31'h0, self_occupied_out}, 32'h0);
            apb(1'b0, `HCMP_A_STATUS, 32'h0);
            check({28'h0, q[5:3], q[0]}, 32'h7);
            peer_occupied_in <= 1'b0;
            mwait();
            check(q, 32'hC0DE0001);
        end
    endtask : t_peer

    task automatic t_host;
        hacc(1'b1, 8'h01, 32'h11223344);
        apb(1'b0, 8'h24, 32'h0);
        check(q, 32'h44332211);
        hacc(1'b0, 8'h01, 32'h0);
        check(q, 32'h11223344);
        apb(1'b1, `HCMP_A_OUTBOX, 32'hA1B2C3D4);
        hacc(1'b0, `HCMP_H_OUTBOX, 32'h0);
        check(q, 32'hD4C3B2A1);
        hacc(1'b1, `HCMP_H_GPIO, 32'h01020304);
        check(gpio_out, 32'h04030201);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, perr}, 32'h1);
    endtask : t_host

    task automatic t_misc;
        device_addr_in <= 4'h3;
        hacc(1'b0, 8'h01, 32'h0);
        check({30'h0, ok, host_ack_oe_n}, 32'h1);
        device_addr_in <= 4'h5;
        apb(1'b1, `HCMP_A_HIRQ, 32'h1);
        @(negedge clk);
        check({30'h0, host_irq_n, host_irq_oe_n}, 32'h0);
        hacc(1'b1, `HCMP_H_IRQCLR, 32'h0);
        check({31'h0, host_irq_n}, 32'h1);
    endtask : t_misc

    // Second reset with the other strap settings: little endian, GPIO closed to the host, arbitration master
    task automatic t_straps;
        rst <= 1'b1;
        {host_endian_strap, link_control_strap, arb_master_strap} <= 3'h1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, `HCMP_A_STATUS, 32'h0);
        check(q, 32'h00000020);
        hacc(1'b1, 8'h02, 32'h11223344);
        apb(1'b0, 8'h28, 32'h0);
        check(q, 32'h11223344);
        hacc(1'b1, `HCMP_H_GPIO, 32'h00000005);
        hacc(1'b0, `HCMP_H_GPIO, 32'h0);
        check(gpio_out | q, 32'h0);
        apb(1'b1, `HCMP_A_MADDR, 32'h000000A5);
        apb(1'b1, `HCMP_A_WDATA, 32'h0);
        peer_occupied_in <= 1'b1;
        apb(1'b1, `HCMP_A_CTRL, 32'h00000005);
        mwait();
        check(q, 32'hC0DE0001);
        peer_occupied_in <= 1'b0;
    endtask : t_straps

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, peer_occupied_in, paddr, pwdata, host_reg_addr, host_data_in} = '0;
        {host_sel_n, host_read_n, host_write_n} = 3'h7;
        device_addr_in = 4'h5;
        device_id_strap = 4'h5;
        {host_endian_strap, link_control_strap, arb_master_strap} = 3'h6;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_mem();
        t_peer();
        t_host();
        t_misc();
        t_straps();
        final_report();
    end
endmodule : tb_top

`default_nettype wire
